// ===== rtl/flow_ctl_pkg.sv
package flow_ctl_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFF_COMMAND = 8'h00;
	localparam logic [7:0] OFF_OPTION_TWO = 8'h04;
	localparam logic [7:0] OFF_OPTION_THREE = 8'h08;
	localparam logic [7:0] OFF_MODEM_OPTION_ONE = 8'h0C;
	localparam logic [7:0] OFF_SPECIAL_ONE = 8'h10;
	localparam logic [7:0] OFF_SPECIAL_TWO = 8'h14;
	localparam logic [7:0] OFF_SPECIAL_THREE = 8'h18;
	localparam logic [7:0] OFF_SPECIAL_FOUR = 8'h1C;
	localparam logic [7:0] OFF_FLOW_STATUS = 8'h20;
	localparam logic [7:0] OFF_TX_DATA = 8'h24;

	// Command codes written to the command register.
	localparam logic [7:0] CMD_TX_DISABLE = 8'h04;
	localparam logic [7:0] CMD_TX_ENABLE = 8'h08;
	localparam logic [4:0] CMD_SEND_SPECIAL = 5'h04;

	// Option register two field positions.
	localparam int O2_CTS_AUTO = 1;
	localparam int O2_RTS_AUTO = 2;
	localparam int O2_INBAND = 6;

	// Option register three field positions.
	localparam int O3_RX_REPORT = 3;
	localparam int O3_DETECT = 4;
	localparam int O3_TRANSPARENCY = 5;
	localparam int O3_XOFF_PAIR = 6;
	localparam int O3_XON_PAIR = 7;

	// Flow status register field positions.
	localparam int ST_REMOTE_ON = 0;
	localparam int ST_REMOTE_OFF = 1;
	localparam int ST_RX_ON_SENT = 2;
	localparam int ST_RX_OFF_SENT = 3;
	localparam int ST_TX_ENABLED = 4;
	localparam int ST_FIFO_FULL = 5;
	localparam int ST_SPECIAL_PENDING = 6;

	// Reset values.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// Timing: system clock and default line rate; bit time rounds down.
	localparam int CLK_HZ = 100_000_000;
	localparam int DEFAULT_BAUD = 115_200;
	localparam int BIT_CYCLES = CLK_HZ / DEFAULT_BAUD;
	localparam int FRAME_BITS = 10;

	// Transmit shifter states.
	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_BUSY = 2'b10
	} shift_state_t;

endpackage

// ===== rtl/serial_flow_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: Command low three bits pick special character.
// R2: Pair mode sends full two-character sequence.
// R3: Specials go out despite disable or flow-off.
// R4: Specials bypass FIFO, start within two characters.
// R5: Specials wait for an active break.
// R6: Sent Xoff clears flow-on, sets flow-off.
// R7: Sent Xon clears flow-off, sets flow-on.
// R8: Received data clears flow-on sent bit.
// R9: Flow characters in FIFO are ignored.
// R10: Gating acts on FIFO to holding move.
// R11: Flow options in option two; threshold elsewhere.
// R12: Status shows enable and remote flow state.
// R13: Inband flow acts regardless of transparency.
// R14: Transparency drops received flow characters.
// R15: Reported flow characters carry special status.
// R16: Disable halts after the current and the held characters finish.
// R17: CTS auto mode gates each FIFO move.
// R18: Up to two characters follow CTS negation.
// R19: Specials ignore CTS in auto mode.
// R20: RTS auto asserted throughout every transmission.
// R21: RTS held until last stop bit ends.
// R22: Xon is char one, Xoff char two.
// R23: Pending special latched until its last character is loaded, then cleared.
module serial_flow_control import flow_ctl_pkg::*; #(
	parameter int FIFO_DEPTH = 8,
	parameter int BIT_TICKS = BIT_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Received characters from the channel receiver.
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_error,
	// Characters delivered toward the host receive path.
	output logic deliver_valid,
	output logic [7:0] deliver_data,
	output logic deliver_special,
	output logic [2:0] deliver_match,
	// Line side.
	input wire logic break_active,
	input wire logic cts_pin,
	output logic txd,
	output logic rts
);

	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int TW = $clog2(BIT_TICKS + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(BIT_TICKS - 1);
	localparam logic [3:0] BITS_LAST = 4'(FRAME_BITS - 1);

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][7:0] fifo;
		logic [AW-1:0] rd_ptr;
		logic [AW-1:0] wr_ptr;
		logic [AW:0] count;
		logic hold_valid;
		logic [7:0] hold_char;
		shift_state_t sh_state;
		logic [9:0] frame;
		logic [3:0] bit_idx;
		logic [TW-1:0] tick;
		logic tx_line;
		logic sh_tail;
		logic pend;
		logic [2:0] pend_sel;
		logic pend_second;
		logic [7:0] channel_option_two;
		logic [7:0] channel_option_three;
		logic [7:0] modem_change_option_one;
		logic [3:0][7:0] special_char;
		logic transmitter_enabled;
		logic remote_flow_off;
		logic remote_flow_on;
		logic rx_flow_off_sent;
		logic rx_flow_on_sent;
		logic prev_first_on;
		logic prev_first_off;
		logic [1:0] cts_sync;
		logic [31:0] rdata;
		logic dv;
		logic [7:0] ddata;
		logic dspecial;
		logic [2:0] dmatch;
	} state_t;

	state_t s_q, s_d;

	// Special character lookup, used for sends and for matching.
	function automatic logic [7:0] spec(input state_t s, input logic [1:0] idx);
		spec = s.special_char[idx];
	endfunction

	// Address decode shared by reads and writes.
	function automatic logic mapped(input logic [7:0] a);
		if (a == OFF_COMMAND) begin
			mapped = 1'b1;
		end else if (a >= OFF_OPTION_TWO && a <= OFF_TX_DATA && a[1:0] == 2'b00) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	endfunction

	logic cts_ok;
	logic setup;
	logic wr_en;
	logic xon_pair;
	logic xoff_pair;
	logic on_hit;
	logic off_hit;
	logic is_flow;
	logic [2:0] match_idx;
	logic [7:0] st_byte;

	// The bus always answers in the access cycle; unmapped addresses flag an error.
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign prdata = s_q.rdata;
	assign deliver_valid = s_q.dv;
	assign deliver_data = s_q.ddata;
	assign deliver_special = s_q.dspecial;
	assign deliver_match = s_q.dmatch;
	assign txd = s_q.tx_line;

	// Pair modes and the synchronised clear-to-send level.
	assign xon_pair = s_q.channel_option_three[O3_XON_PAIR];
	assign xoff_pair = s_q.channel_option_three[O3_XOFF_PAIR];
	assign cts_ok = ~s_q.channel_option_two[O2_CTS_AUTO] | s_q.cts_sync[1];

	// RTS in auto mode covers queued data, holding, shifting, specials and breaks.
	// The line lags the shifter by one cycle, so the tail flag keeps RTS up to the stop bit's end.
	assign rts = s_q.channel_option_two[O2_RTS_AUTO] & ((s_q.count != '0) | s_q.hold_valid |
		(s_q.sh_state == SH_BUSY) | s_q.sh_tail | s_q.pend | break_active); // R20 R21

	// Status byte seen by software.
	always_comb begin
		st_byte = RESET_BYTE;
		st_byte[ST_REMOTE_ON] = s_q.remote_flow_on; // R12
		st_byte[ST_REMOTE_OFF] = s_q.remote_flow_off; // R12
		st_byte[ST_RX_ON_SENT] = s_q.rx_flow_on_sent;
		st_byte[ST_RX_OFF_SENT] = s_q.rx_flow_off_sent;
		st_byte[ST_TX_ENABLED] = s_q.transmitter_enabled; // R12
		st_byte[ST_FIFO_FULL] = (s_q.count == (AW+1)'(FIFO_DEPTH));
		st_byte[ST_SPECIAL_PENDING] = s_q.pend;
	end

	// Received character matching against the programmed specials.
	always_comb begin
		on_hit = 1'b0;
		off_hit = 1'b0;
		match_idx = 3'd0;
		if (rx_valid && !rx_error && s_q.channel_option_three[O3_DETECT]) begin
			if (rx_data == spec(s_q, 2'd0)) begin
				match_idx = 3'd1;
			end else if (rx_data == spec(s_q, 2'd1)) begin
				match_idx = 3'd2;
			end else if (rx_data == spec(s_q, 2'd2)) begin
				match_idx = 3'd3;
			end else if (rx_data == spec(s_q, 2'd3)) begin
				match_idx = 3'd4;
			end
			// Single mode: one is Xon, two is Xoff; pair mode ends on three or four.
			on_hit = xon_pair ? (s_q.prev_first_on && rx_data == spec(s_q, 2'd2)) :
				(rx_data == spec(s_q, 2'd0)); // R22
			off_hit = xoff_pair ? (s_q.prev_first_off && rx_data == spec(s_q, 2'd3)) :
				(rx_data == spec(s_q, 2'd1)); // R22
		end
		is_flow = on_hit | off_hit;
	end

	// Next-state logic for the whole channel.
	always_comb begin
		logic [7:0] cmd;
		logic fifo_pop;
		logic fifo_push;
		logic load_special;
		logic load_hold;
		logic [7:0] sp_char;
		logic sp_last;
		cmd = pwdata[7:0];
		fifo_pop = 1'b0;
		fifo_push = 1'b0;
		load_special = 1'b0;
		load_hold = 1'b0;
		sp_char = RESET_BYTE;
		sp_last = 1'b1;
		s_d = s_q;
		s_d.dv = 1'b0;
		s_d.sh_tail = 1'b0;
		s_d.cts_sync = {s_q.cts_sync[0], cts_pin};

		// Register reads are captured in the setup cycle so data leaves a flop.
		if (setup && !pwrite) begin
			if (paddr == OFF_OPTION_TWO) begin
				s_d.rdata = {24'h00_0000, s_q.channel_option_two};
			end else if (paddr == OFF_OPTION_THREE) begin
				s_d.rdata = {24'h00_0000, s_q.channel_option_three};
			end else if (paddr == OFF_MODEM_OPTION_ONE) begin
				s_d.rdata = {24'h00_0000, s_q.modem_change_option_one};
			end else if (paddr >= OFF_SPECIAL_ONE && paddr <= OFF_SPECIAL_FOUR) begin
				s_d.rdata = {24'h00_0000, spec(s_q, paddr[3:2])};
			end else if (paddr == OFF_FLOW_STATUS) begin
				s_d.rdata = {24'h00_0000, st_byte};
			end else begin
				s_d.rdata = RESET_WORD;
			end
		end

		// Register writes; a full FIFO drops the written byte.
		if (wr_en) begin
			if (paddr == OFF_COMMAND) begin
				if (cmd[7:3] == CMD_SEND_SPECIAL && cmd[2:0] >= 3'd1 && cmd[2:0] <= 3'd4) begin
					s_d.pend = 1'b1; // R23
					s_d.pend_sel = cmd[2:0]; // R1
					s_d.pend_second = 1'b0;
				end else if (cmd == CMD_TX_ENABLE || cmd == CMD_TX_DISABLE) begin
					s_d.transmitter_enabled = (cmd == CMD_TX_ENABLE);
					s_d.remote_flow_off = 1'b0;
					s_d.remote_flow_on = 1'b0;
				end
			end else if (paddr == OFF_OPTION_TWO) begin
				s_d.channel_option_two = cmd; // R11
			end else if (paddr == OFF_OPTION_THREE) begin
				s_d.channel_option_three = cmd;
			end else if (paddr == OFF_MODEM_OPTION_ONE) begin
				s_d.modem_change_option_one = cmd; // R11
			end else if (paddr >= OFF_SPECIAL_ONE && paddr <= OFF_SPECIAL_FOUR) begin
				s_d.special_char[paddr[3:2]] = cmd;
			end else if (paddr == OFF_TX_DATA) begin
				fifo_push = (s_q.count != (AW+1)'(FIFO_DEPTH)); // R9
			end
		end

		// Remote flow from received Xon/Xoff, independent of transparency.
		if (rx_valid) begin
			s_d.prev_first_on = ~rx_error & (rx_data == spec(s_q, 2'd0));
			s_d.prev_first_off = ~rx_error & (rx_data == spec(s_q, 2'd1));
			s_d.rx_flow_on_sent = 1'b0; // R8
			if (s_q.channel_option_two[O2_INBAND] && s_q.channel_option_three[O3_DETECT]) begin
				if (off_hit) begin
					s_d.remote_flow_off = 1'b1; // R13
					s_d.remote_flow_on = 1'b0;
				end else if (on_hit) begin
					s_d.remote_flow_off = 1'b0; // R13
					s_d.remote_flow_on = 1'b1;
				end
			end
			// Deliver to the host unless a flow character is stripped.
			if (!(is_flow && s_q.channel_option_three[O3_TRANSPARENCY])) begin // R14
				s_d.dv = 1'b1;
				s_d.ddata = rx_data;
				s_d.dspecial = s_q.channel_option_three[O3_RX_REPORT] && match_idx != 3'd0; // R15
				s_d.dmatch = s_d.dspecial ? match_idx : 3'd0; // R15
			end
		end

		// A special character takes the free shifter ahead of holding and FIFO data.
		if (s_q.sh_state == SH_IDLE && s_q.pend && !break_active) begin // R3 R4 R5 R19
			load_special = 1'b1;
			sp_char = spec(s_q, 2'(s_q.pend_sel - 3'd1)); // R1
			if (s_q.pend_second) begin
				sp_char = spec(s_q, 2'(s_q.pend_sel + 3'd1)); // R2
			end else if ((s_q.pend_sel == 3'd1 && xon_pair) || (s_q.pend_sel == 3'd2 && xoff_pair)) begin
				sp_last = 1'b0; // R2
			end
			s_d.pend = ~sp_last; // R23
			s_d.pend_second = ~sp_last;
			if (sp_last && s_q.pend_sel == 3'd2) begin
				s_d.rx_flow_on_sent = 1'b0; // R6
				s_d.rx_flow_off_sent = 1'b1; // R6
			end else if (sp_last && s_q.pend_sel == 3'd1) begin
				s_d.rx_flow_off_sent = 1'b0; // R7
				s_d.rx_flow_on_sent = 1'b1; // R7
			end
		end else if (s_q.sh_state == SH_IDLE && s_q.hold_valid) begin
			load_hold = 1'b1; // R10 R18
		end

		// Gated FIFO to holding move: enable, remote flow and CTS act only here.
		if ((!s_q.hold_valid || load_hold) && s_q.count != '0 && s_q.transmitter_enabled &&
			!s_q.remote_flow_off && cts_ok) begin // R10 R16 R17
			fifo_pop = 1'b1;
			s_d.hold_valid = 1'b1;
			s_d.hold_char = s_q.fifo[s_q.rd_ptr];
			s_d.rd_ptr = AW'(s_q.rd_ptr + 1'b1);
			// A flow-on set by an Xon in this same cycle wins over the resume clear.
			s_d.remote_flow_on = s_d.remote_flow_on & ~s_q.remote_flow_on;
		end else if (load_hold) begin
			s_d.hold_valid = 1'b0;
		end

		if (fifo_push) begin
			s_d.fifo[s_q.wr_ptr] = cmd;
			s_d.wr_ptr = AW'(s_q.wr_ptr + 1'b1);
		end
		s_d.count = (AW+1)'(s_q.count + fifo_push - fifo_pop);

		// Shifter: start bit, eight data bits, stop bit, then idle high.
		case (s_q.sh_state)
			SH_IDLE: begin
				s_d.tx_line = 1'b1;
				if (load_special || load_hold) begin
					s_d.frame = {1'b1, load_special ? sp_char : s_q.hold_char, 1'b0};
					s_d.bit_idx = 4'd0;
					s_d.tick = '0;
					s_d.sh_state = SH_BUSY;
				end
			end
			SH_BUSY: begin
				s_d.tx_line = s_q.frame[0];
				if (s_q.tick == TICK_LAST) begin
					s_d.tick = '0;
					s_d.frame = {1'b1, s_q.frame[9:1]};
					s_d.bit_idx = 4'(s_q.bit_idx + 1'b1);
					if (s_q.bit_idx == BITS_LAST) begin
						s_d.sh_state = SH_IDLE; // R16 R21
						s_d.sh_tail = 1'b1; // R21
					end
				end else begin
					s_d.tick = TW'(s_q.tick + 1'b1);
				end
			end
			default: begin
				s_d.sh_state = SH_IDLE;
			end
		endcase
	end

	// Single state register; reset returns every field to a constant.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.sh_state <= SH_IDLE;
			s_q.tx_line <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // serial_flow_control

// ===== test/flow_ctl_monitor.sv
`timescale 1ns/100ps
module flow_ctl_monitor import flow_ctl_pkg::*; #(
	parameter int BIT_TICKS = BIT_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Receive path.
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_error,
	input wire logic deliver_valid,
	input wire logic [7:0] deliver_data,
	// Line side.
	input wire logic break_active,
	input wire logic cts_pin,
	input wire logic txd,
	input wire logic rts
);
	localparam int SPEC_MAX = 20 * BIT_TICKS + 8;
	logic [7:0] opt2_q, opt3_q, sc1_q, sc2_q;
	logic [15:0] high_q;
	logic [1:0] late_q;
	logic [15:0] fbusy_q;
	logic [31:0] wait_q;
	logic wr, spec;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Decoded bus writes.
	assign wr = psel && penable && pwrite;
	assign spec = wr && paddr == OFF_COMMAND && pwdata[7:3] == CMD_SEND_SPECIAL
		&& pwdata[2:0] inside {[3'd1:3'd4]};
	// Shadow copies tell the RTS, delivery, strip and CTS properties which modes are live.
	// A command write restarts the late-start count, since a special may pass CTS.
	always_ff @(posedge clk) begin
		if (rst) begin
			opt2_q <= 8'h00;
			opt3_q <= 8'h00;
			sc1_q <= 8'h00;
			sc2_q <= 8'h00;
			high_q <= 16'h0000;
			late_q <= 2'h0;
			fbusy_q <= 16'h0000;
			wait_q <= 32'h0000_0000;
		end else begin
			if (wr && paddr == OFF_OPTION_TWO) opt2_q <= pwdata[7:0];
			if (wr && paddr == OFF_OPTION_THREE) opt3_q <= pwdata[7:0];
			if (wr && paddr == OFF_SPECIAL_ONE) sc1_q <= pwdata[7:0];
			if (wr && paddr == OFF_SPECIAL_TWO) sc2_q <= pwdata[7:0];
			high_q <= !txd ? 16'h0000 : high_q + {15'h0000, high_q != 16'hffff};
			// Falling data bits inside a frame must not count as new frame starts.
			if (fbusy_q != 16'h0000) fbusy_q <= fbusy_q - 16'h0001;
			else if ($fell(txd)) fbusy_q <= 16'(9 * BIT_TICKS);
			if (cts_pin || (wr && paddr == OFF_COMMAND)) late_q <= 2'h0;
			else if ($fell(txd) && fbusy_q == 16'h0000 && late_q != 2'h3) late_q <= late_q + 2'h1;
			// Cycles since a special request with the line still idle high.
			if (!txd || break_active) wait_q <= 32'h0000_0000;
			else if (spec) wait_q <= 32'h0000_0001;
			else if (wait_q != 32'h0000_0000) wait_q <= wait_q + 32'h0000_0001;
		end
	end
	property p_rts_off;
		!opt2_q[O2_RTS_AUTO] |-> !rts;
	endproperty
	a_rts_off: assert property (p_rts_off) else $error("rts high outside auto mode");
	property p_rts_frame;
		opt2_q[O2_RTS_AUTO] && $fell(txd) |-> rts [*8];
	endproperty
	a_rts_frame: assert property (p_rts_frame) else $error("rts low in frame");
	property p_rts_tail;
		opt2_q[O2_RTS_AUTO] && $fell(rts) |-> high_q >= BIT_TICKS;
	endproperty
	a_rts_tail: assert property (p_rts_tail) else $error("rts fell before stop bit");
	property p_special;
		wait_q <= SPEC_MAX;
	endproperty
	a_special: assert property (p_special) else $error("special did not start");
	property p_deliver;
		rx_valid && !opt3_q[O3_TRANSPARENCY] |=> deliver_valid && deliver_data == $past(rx_data);
	endproperty
	a_deliver: assert property (p_deliver) else $error("character not delivered");
	property p_strip;
		rx_valid && !rx_error && opt3_q[O3_TRANSPARENCY] && opt3_q[O3_DETECT]
			&& opt2_q[O2_INBAND] && opt3_q[7:6] == 2'b00
			&& (rx_data == sc1_q || rx_data == sc2_q) |=> !deliver_valid;
	endproperty
	a_strip: assert property (p_strip) else $error("flow character delivered");
	property p_cts;
		opt2_q[O2_CTS_AUTO] |-> late_q <= 2'h2;
	endproperty
	a_cts: assert property (p_cts) else $error("too many starts after CTS drop");
	property p_status;
		psel && penable && !pwrite && paddr == OFF_FLOW_STATUS
			|-> prdata[3:2] != 2'b11 && prdata[1:0] != 2'b11;
	endproperty
	a_status: assert property (p_status) else $error("illegal flow status");
	c_special: cover property (spec);
	c_rts_end: cover property (opt2_q[O2_RTS_AUTO] && $fell(rts));
	c_strip: cover property (rx_valid && opt3_q[O3_TRANSPARENCY]);
endmodule // flow_ctl_monitor

bind serial_flow_control flow_ctl_monitor #(.BIT_TICKS(BIT_TICKS)) i_flow_ctl_monitor (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_error(rx_error), .deliver_valid(deliver_valid),
	.deliver_data(deliver_data), .break_active(break_active), .cts_pin(cts_pin),
	.txd(txd), .rts(rts)
);

// ===== test/remote_dev.sv
`timescale 1ns/100ps
module remote_dev #(
	parameter int BIT_TICKS = 4
) (
	// System clock.
	input wire logic clk,
	// Line side.
	input wire logic txd,
	output logic cts_pin,
	// Characters sent by this device, as the channel receiver hands them on.
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_error
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// Ready from the start; the error flag rises only when a send asks for it.
	initial begin
		cts_pin = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_error = 1'b0;
	end
	// Mid-bit sampling of each frame; the stop bit is waited out, not checked.
	always begin
		@(negedge txd);
		repeat (BIT_TICKS / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_TICKS) @(posedge clk);
			sh[i] = txd;
		end
		got.push_back(sh);
		repeat (BIT_TICKS) @(posedge clk);
	end
	// Data is inverted outside the strobe so a stale value cannot pass.
	task automatic send(input logic [7:0] b, input logic err);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_error <= err;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		rx_error <= 1'b0;
	endtask
	task automatic set_cts(input logic v);
		cts_pin <= v;
	endtask
endmodule // remote_dev

// ===== test/serial_flow_control_tb_top.sv
`timescale 1ns/100ps
module serial_flow_control_tb_top import flow_ctl_pkg::*;;
	logic clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic break_active = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic [7:0] rx_data;
	logic [7:0] dd;
	logic [2:0] dm;
	logic ds;
	logic pready, pslverr, rx_valid, rx_error, cts_pin, txd, rts, dv, e;
	int mismatches = 0;
	int n_compared = 0;
	int n_del = 0;
	// 100 MHz clock.
	always #5 clk = ~clk;
	// Counting deliveries makes a stripped flow character visible.
	always @(posedge clk) if (dv === 1'b1) n_del <= n_del + 1;
	serial_flow_control #(.BIT_TICKS(4)) i_serial_flow_control (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
		.deliver_valid(dv), .deliver_data(dd), .deliver_special(ds), .deliver_match(dm),
		.break_active(break_active), .cts_pin(cts_pin), .txd(txd), .rts(rts)
	);
	remote_dev #(.BIT_TICKS(4)) i_remote_dev (
		.clk(clk), .txd(txd), .cts_pin(cts_pin), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_error(rx_error)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// One APB transfer; the request holds until pready is seen.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps a following call from driving psel twice in one step.
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, {24'h00_0000, x});
	endtask
	task automatic expect_char(input logic [7:0] x);
		for (int i = 0; i < 200 && i_remote_dev.got.size() == 0; i++) @(posedge clk);
		if (i_remote_dev.got.size() == 0) chk(32'hffff_ffff, {24'h00_0000, x});
		else chk({24'h00_0000, i_remote_dev.got.pop_front()}, {24'h00_0000, x});
	endtask
	task automatic idle;
		repeat (120) @(posedge clk);
		chk(i_remote_dev.got.size(), 32'h0000_0000);
	endtask
	task automatic s_regs;
		rd(OFF_FLOW_STATUS, 8'h00);
		wr(OFF_OPTION_TWO, 8'h46);
		rd(OFF_OPTION_TWO, 8'h46);
		rd(8'h40, 8'h00);
		chk({31'h0000_0000, e}, 32'h0000_0001);
	endtask
	task automatic s_special;
		wr(OFF_SPECIAL_ONE, 8'h11);
		wr(OFF_SPECIAL_TWO, 8'h13);
		wr(OFF_SPECIAL_THREE, 8'h51);
		wr(OFF_SPECIAL_FOUR, 8'h53);
		wr(OFF_COMMAND, 8'h22);
		expect_char(8'h13);
		rd(OFF_FLOW_STATUS, 8'h08);
		wr(OFF_COMMAND, 8'h21);
		expect_char(8'h11);
		rd(OFF_FLOW_STATUS, 8'h04);
		i_remote_dev.send(8'h41, 1'b0);
		rd(OFF_FLOW_STATUS, 8'h00);
		wr(OFF_COMMAND, 8'h23);
		expect_char(8'h51);
		wr(OFF_COMMAND, 8'h24);
		expect_char(8'h53);
		rd(OFF_FLOW_STATUS, 8'h00);
	endtask
	task automatic s_pair;
		wr(OFF_OPTION_THREE, 8'hc0);
		wr(OFF_COMMAND, 8'h22);
		expect_char(8'h13);
		expect_char(8'h53);
		wr(OFF_COMMAND, 8'h21);
		expect_char(8'h11);
		expect_char(8'h51);
		rd(OFF_FLOW_STATUS, 8'h04);
	endtask
	task automatic s_fifo;
		wr(OFF_COMMAND, CMD_TX_ENABLE);
		wr(OFF_TX_DATA, 8'h13);
		expect_char(8'h13);
		rd(OFF_FLOW_STATUS, 8'h14);
		wr(OFF_COMMAND, CMD_TX_DISABLE);
		wr(OFF_TX_DATA, 8'h41);
		idle();
		rd(OFF_FLOW_STATUS, 8'h04);
	endtask
	task automatic s_inband;
		int n;
		wr(OFF_OPTION_TWO, 8'h40);
		wr(OFF_OPTION_THREE, 8'h30);
		wr(OFF_COMMAND, CMD_TX_ENABLE);
		expect_char(8'h41);
		n = n_del;
		i_remote_dev.send(8'h13, 1'b0);
		rd(OFF_FLOW_STATUS, 8'h12);
		wr(OFF_TX_DATA, 8'h55);
		idle();
		i_remote_dev.send(8'h11, 1'b0);
		expect_char(8'h55);
		chk(n_del, n);
		rd(OFF_FLOW_STATUS, 8'h10);
	endtask
	task automatic s_cts;
		i_remote_dev.set_cts(1'b0);
		wr(OFF_OPTION_TWO, 8'h06);
		wr(OFF_OPTION_THREE, 8'h00);
		wr(OFF_TX_DATA, 8'h66);
		idle();
		wr(OFF_COMMAND, 8'h21);
		expect_char(8'h11);
		i_remote_dev.set_cts(1'b1);
		expect_char(8'h66);
	endtask
	task automatic s_break;
		break_active <= 1'b1;
		wr(OFF_COMMAND, 8'h22);
		idle();
		break_active <= 1'b0;
		expect_char(8'h13);
		rd(OFF_FLOW_STATUS, 8'h18);
		// An errored match is delivered plain; a clean one carries its special index.
		wr(OFF_OPTION_THREE, 8'h18);
		i_remote_dev.send(8'h51, 1'b1);
		@(posedge clk);
		chk({20'h0_0000, ds, dm, dd}, {20'h0_0000, 1'b0, 3'd0, 8'h51});
		i_remote_dev.send(8'h51, 1'b0);
		@(posedge clk);
		chk({20'h0_0000, ds, dm, dd}, {20'h0_0000, 1'b1, 3'd3, 8'h51});
	endtask
	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Main sequence after a three-cycle reset.
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		s_regs();
		s_special();
		s_pair();
		s_fifo();
		s_inband();
		s_cts();
		s_break();
		end_of_test();
	end
	// Watchdog well beyond the expected run of under two thousand cycles.
	initial begin
		repeat (10000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule // serial_flow_control_tb_top
